// >>> kdb_bank.sv
// Setting and status bank for the serial-to-analog key converter
// Assumes all inputs synchronous to REF_CLK; remote writes are one-cycle strobes
//
// Overview of operation
// - Colour lock picks arbitrary, matching or opposite colour-field phase.
// - Colour lock applies only while the composite format is active.
// - Blanking ends line 10 narrow, 20 wide; remote range 6 to 25, default 20.
// - Error-check packet insertion into loop output, on by default.
// - Horizontal timing signed within plus or minus 1716 clocks, default zero.
// - Genlock path delay reported in whole lines.
// - Save then slot one to five copies the whole setup there.
// - Recall loads an occupied slot; empty slot is reported empty.
// - Lock flag set only when equalised and receiver clock locked.
// - Input present and equalised flag plus measured cable length.
// - Error-check packet presence and checksum error flags.
// - Audio ancillary data presence flag.
// - Reference status and genlock option fitted flag.
// - Max cable 0 to 350 m remotely, default zero, local fixed 300 m.
// - Test enable off by default; pattern ramp, 75 or 100 bars, default 75.
// - Gain 0 to 120 percent default 100; pedestal within 10 IRE default 0.
// - Reference digital, external or master, default digital; local external.
// - Setup offset on the key output, on by default.
// - Parameters above the controller level are refused and shown unavailable.
// - Remote settings take precedence over front-panel switches.
// - Local mode gives switchless parameters their defaults, but fixes reference external, cable 300 m and colour lock matching.
`timescale 1ns/1ps
module kdb_bank
  import kdb_pkg::*;
(
  // Clock, reset, enable
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  // Mode and front panel switches
  input wire logic REMOTE,
  input wire logic SW_BURST,
  input wire logic SW_SETUP,
  input wire logic SW_NARROW,
  input wire logic SW_EDH,
  // Remote parameter write
  input wire logic WR,
  input wire logic [3:0] WR_SEL,
  input wire logic signed [15:0] WR_VAL,
  input wire logic [1:0] USER_LEVEL,
  // Setup memory commands
  input wire logic SAVE,
  input wire logic RECALL,
  input wire logic [2:0] SLOT,
  // Datapath status inputs
  input wire logic RX_EQ,
  input wire logic RX_LOCK,
  input wire logic [8:0] RX_CABLE,
  input wire logic RX_EDH,
  input wire logic RX_EDH_ERR,
  input wire logic RX_AUDIO,
  input wire logic REF_OK,
  input wire logic GL_FITTED,
  input wire logic [10:0] GL_DELAY,
  // Active settings
  output logic FORMAT,
  output logic SETUP_ON,
  output logic [1:0] REF_SRC,
  output logic [1:0] FIELD_PHASE,
  output logic [8:0] CABLE_MAX,
  output logic TEST_EN,
  output logic [1:0] TEST_TYPE,
  output logic [4:0] VBLANK_END,
  output logic EDH_INS,
  output logic signed [7:0] FINE_PHASE,
  output logic signed [11:0] HOR_TIMING,
  output logic signed [10:0] VERT_TIMING,
  output logic [6:0] GAIN,
  output logic signed [4:0] PEDESTAL,
  // Status and answers
  output logic [13:0] PARAM_AVAIL,
  output logic WR_REFUSED,
  output logic SLOT_EMPTY,
  output logic LOCK_OK,
  output logic EQ_OK,
  output logic [8:0] CABLE_LEN,
  output logic EDH_PRESENT,
  output logic EDH_ERROR,
  output logic AUDIO_PRESENT,
  output logic REF_STATUS,
  output logic GL_PRESENT,
  output logic [10:0] DELAY_LINES
);
  // Remote setup store
  logic fmt, setup, edh, ten;
  logic [1:0] ref_src, ttype;
  kdb_clock_t clk_lock;
  logic [8:0] cable;
  logic [4:0] vblk;
  logic signed [7:0] fine;
  logic signed [11:0] ht;
  logic signed [10:0] vt;
  logic [6:0] gain;
  logic signed [4:0] ped;
  logic [SETUP_W-1:0] packed_setup, mem_data;
  logic mem_full;
  logic next_fmt, next_setup, next_edh, next_ten;
  logic [1:0] next_ref_src, next_ttype;
  kdb_clock_t next_clk_lock;
  logic [8:0] next_cable;
  logic [4:0] next_vblk;
  logic signed [7:0] next_fine;
  logic signed [11:0] next_ht;
  logic signed [10:0] next_vt;
  logic [6:0] next_gain;
  logic signed [4:0] next_ped;
  logic [1:0] lvl;
  logic allowed;
  logic [13:0] avail;

  assign packed_setup = {fmt, setup, ref_src, clk_lock, cable, ten, ttype, vblk, edh,
                         fine, ht, vt, gain, ped};

  kdb_slot_mem u_mem (
    .clk(REF_CLK),
    .rst(RST),
    .ce(CE),
    .save(SAVE),
    .save_slot(SLOT),
    .save_data(packed_setup),
    .rd_slot(SLOT),
    .rd_data(mem_data),
    .rd_full(mem_full)
  );

  // Access level of each parameter
  always_comb begin
    case (WR_SEL)
      P_TEN, P_TTYPE: lvl = LVL_2;
      P_GAIN, P_PED: lvl = LVL_1;
      default: lvl = LVL_3;
    endcase
  end

  always_comb begin
    for (int i = 0; i < 14; i++) begin
      if (i == 5 || i == 6) begin
        avail[i] = USER_LEVEL >= LVL_2;
      end else if (i == 12 || i == 13) begin
        avail[i] = USER_LEVEL >= LVL_1;
      end else begin
        avail[i] = USER_LEVEL >= LVL_3;
      end
    end
  end
  assign allowed = REMOTE && (USER_LEVEL >= lvl);

  always_comb begin
    next_fmt = fmt;
    next_setup = setup;
    next_edh = edh;
    next_ten = ten;
    next_ref_src = ref_src;
    next_ttype = ttype;
    next_clk_lock = clk_lock;
    next_cable = cable;
    next_vblk = vblk;
    next_fine = fine;
    next_ht = ht;
    next_vt = vt;
    next_gain = gain;
    next_ped = ped;
    if (RECALL && mem_full) begin
      {next_fmt, next_setup, next_ref_src, next_clk_lock, next_cable, next_ten, next_ttype,
       next_vblk, next_edh, next_fine, next_ht, next_vt, next_gain, next_ped} = mem_data;
    end else if (WR && allowed) begin
      case (WR_SEL)
        P_FMT: next_fmt = WR_VAL[0];
        P_SETUP: next_setup = WR_VAL[0];
        P_REF: next_ref_src = (WR_VAL > 16'sd2 || WR_VAL < 0) ? REF_MST : WR_VAL[1:0];
        P_CLOCK: next_clk_lock = (WR_VAL > 16'sd4 || WR_VAL < 0) ? KDB_CL_INV7 : kdb_clock_t'(WR_VAL[2:0]);
        P_CABLE: next_cable = WR_VAL < 0 ? 9'h0 : (WR_VAL > $signed({7'h0, CBL_MAX}) ? CBL_MAX : WR_VAL[8:0]);
        P_TEN: next_ten = WR_VAL[0];
        P_TTYPE: next_ttype = (WR_VAL > 16'sd2 || WR_VAL < 0) ? TP_B100 : WR_VAL[1:0];
        P_VBLK: next_vblk = WR_VAL < $signed({11'h0, VB_MIN}) ? VB_MIN :
                            (WR_VAL > $signed({11'h0, VB_MAX}) ? VB_MAX : WR_VAL[4:0]);
        P_EDH: next_edh = WR_VAL[0];
        P_FINE: next_fine = WR_VAL > 16'(FP_LIM) ? FP_LIM : (WR_VAL < -16'(FP_LIM) ? -FP_LIM : WR_VAL[7:0]);
        P_HT: next_ht = WR_VAL > 16'(HT_LIM) ? HT_LIM : (WR_VAL < -16'(HT_LIM) ? -HT_LIM : WR_VAL[11:0]);
        P_VT: next_vt = WR_VAL > 16'(VT_LIM) ? VT_LIM : (WR_VAL < -16'(VT_LIM) ? -VT_LIM : WR_VAL[10:0]);
        P_GAIN: next_gain = WR_VAL < 0 ? 7'h0 : (WR_VAL > $signed({9'h0, GAIN_MAX}) ? GAIN_MAX : WR_VAL[6:0]);
        P_PED: next_ped = WR_VAL > 16'(PED_LIM) ? PED_LIM : (WR_VAL < -16'(PED_LIM) ? -PED_LIM : WR_VAL[4:0]);
        default: ;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      fmt <= FMT_CPST;
      setup <= 1'b1;
      edh <= 1'b1;
      ten <= 1'b0;
      ref_src <= REF_DIG;
      ttype <= TP_B75;
      clk_lock <= KDB_CL_TWO;
      cable <= CBL_DEF;
      vblk <= VB_WIDE;
      fine <= '0;
      ht <= '0;
      vt <= '0;
      gain <= GAIN_DEF;
      ped <= '0;
    end else if (CE) begin
      fmt <= next_fmt;
      setup <= next_setup;
      edh <= next_edh;
      ten <= next_ten;
      ref_src <= next_ref_src;
      ttype <= next_ttype;
      clk_lock <= next_clk_lock;
      cable <= next_cable;
      vblk <= next_vblk;
      fine <= next_fine;
      ht <= next_ht;
      vt <= next_vt;
      gain <= next_gain;
      ped <= next_ped;
    end
  end

  // Output selection
  logic n_fmt, n_setup, n_edh, n_ten;
  logic [1:0] n_ref, n_tt, n_ph;
  logic [8:0] n_cable;
  logic [4:0] n_vb;
  logic signed [7:0] n_fine;
  logic signed [11:0] n_ht;
  logic signed [10:0] n_vt;
  logic [6:0] n_gain;
  logic signed [4:0] n_ped;

  always_comb begin
    if (REMOTE) begin
      n_fmt = fmt;
      n_setup = setup;
      n_edh = edh;
      n_vb = vblk;
      n_ref = ref_src;
      n_cable = cable;
      n_ten = ten;
      n_tt = ttype;
      n_fine = fine;
      n_ht = ht;
      n_vt = vt;
      n_gain = gain;
      n_ped = ped;
    end else begin
      n_fmt = SW_BURST;
      n_setup = SW_SETUP;
      n_edh = SW_EDH;
      n_vb = SW_NARROW ? VB_NARROW : VB_WIDE;
      n_ref = REF_EXT;
      n_cable = CBL_LOCAL;
      n_ten = 1'b0;
      n_tt = TP_B75;
      n_fine = '0;
      n_ht = '0;
      n_vt = '0;
      n_gain = GAIN_DEF;
      n_ped = '0;
    end
    case (REMOTE ? clk_lock : KDB_CL_NORM)
      KDB_CL_TWO: n_ph = PH_ARB;
      KDB_CL_NORM: n_ph = PH_MATCH;
      KDB_CL_INV3, KDB_CL_INV5, KDB_CL_INV7: n_ph = PH_OPP;
      default: n_ph = PH_ARB;
    endcase
    if (n_fmt != FMT_CPST) begin
      n_ph = PH_ARB;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      FORMAT <= FMT_CPST;
      SETUP_ON <= 1'b1;
      REF_SRC <= REF_DIG;
      FIELD_PHASE <= PH_ARB;
      CABLE_MAX <= CBL_DEF;
      TEST_EN <= 1'b0;
      TEST_TYPE <= TP_B75;
      VBLANK_END <= VB_WIDE;
      EDH_INS <= 1'b1;
      FINE_PHASE <= '0;
      HOR_TIMING <= '0;
      VERT_TIMING <= '0;
      GAIN <= GAIN_DEF;
      PEDESTAL <= '0;
      PARAM_AVAIL <= '0;
      WR_REFUSED <= 1'b0;
      SLOT_EMPTY <= 1'b0;
      LOCK_OK <= 1'b0;
      EQ_OK <= 1'b0;
      CABLE_LEN <= '0;
      EDH_PRESENT <= 1'b0;
      EDH_ERROR <= 1'b0;
      AUDIO_PRESENT <= 1'b0;
      REF_STATUS <= 1'b0;
      GL_PRESENT <= 1'b0;
      DELAY_LINES <= '0;
    end else if (CE) begin
      FORMAT <= n_fmt;
      SETUP_ON <= n_setup;
      REF_SRC <= n_ref;
      FIELD_PHASE <= n_ph;
      CABLE_MAX <= n_cable;
      TEST_EN <= n_ten;
      TEST_TYPE <= n_tt;
      VBLANK_END <= n_vb;
      EDH_INS <= n_edh;
      FINE_PHASE <= n_fine;
      HOR_TIMING <= n_ht;
      VERT_TIMING <= n_vt;
      GAIN <= n_gain;
      PEDESTAL <= n_ped;
      PARAM_AVAIL <= REMOTE ? avail : '0;
      WR_REFUSED <= WR && !allowed;
      SLOT_EMPTY <= RECALL && !mem_full;
      LOCK_OK <= RX_EQ && RX_LOCK;
      EQ_OK <= RX_EQ;
      CABLE_LEN <= RX_CABLE;
      EDH_PRESENT <= RX_EDH;
      EDH_ERROR <= RX_EDH && RX_EDH_ERR;
      AUDIO_PRESENT <= RX_AUDIO;
      REF_STATUS <= REF_OK;
      GL_PRESENT <= GL_FITTED;
      DELAY_LINES <= GL_FITTED ? GL_DELAY : '0;
    end
  end

  // Assertions
  a_lock_flag: assert property (@(posedge REF_CLK) disable iff (RST)
    $rose(LOCK_OK) |-> $past(RX_EQ) && $past(RX_LOCK)) else $error("lock flag without lock");
  a_refuse_write: assert property (@(posedge REF_CLK) disable iff (RST)
    CE && WR && !allowed |=> WR_REFUSED) else $error("low level write not refused");
  a_local_cable: assert property (@(posedge REF_CLK) disable iff (RST)
    CE && !REMOTE |=> CABLE_MAX == CBL_LOCAL) else $error("local cable limit wrong");
  a_ht_range: assert property (@(posedge REF_CLK) disable iff (RST)
    HOR_TIMING <= HT_LIM && HOR_TIMING >= -HT_LIM) else $error("horizontal out of range");
  a_gain_range: assert property (@(posedge REF_CLK) disable iff (RST)
    GAIN <= GAIN_MAX) else $error("gain above limit");
  a_phase_cpst: assert property (@(posedge REF_CLK) disable iff (RST)
    FORMAT != FMT_CPST |-> FIELD_PHASE == PH_ARB) else $error("phase set off composite");
  a_vblk_range: assert property (@(posedge REF_CLK) disable iff (RST)
    VBLANK_END >= VB_MIN && VBLANK_END <= VB_MAX) else $error("blank end out of range");
  a_local_ref: assert property (@(posedge REF_CLK) disable iff (RST)
    CE && !REMOTE |=> REF_SRC == REF_EXT) else $error("local reference wrong");
  a_remote_wins: assert property (@(posedge REF_CLK) disable iff (RST)
    CE && REMOTE |=> EDH_INS == $past(edh)) else $error("switch overrode remote");
endmodule

// >>> kdb_pkg.sv
// Package for the key converter setting bank: field widths, defaults, limits
// Assumes parameters travel as plain ports with no register bus
package kdb_pkg;
  // Output format
  localparam logic FMT_CPST = 1'h1;
  // Colour lock modes
  typedef enum logic [2:0] {
    KDB_CL_TWO = 3'b000,
    KDB_CL_NORM = 3'b001,
    KDB_CL_INV3 = 3'b010,
    KDB_CL_INV5 = 3'b011,
    KDB_CL_INV7 = 3'b100
  } kdb_clock_t;
  // Colour field phase outputs
  localparam logic [1:0] PH_ARB = 2'h0;
  localparam logic [1:0] PH_MATCH = 2'h1;
  localparam logic [1:0] PH_OPP = 2'h2;
  // Reference sources
  localparam logic [1:0] REF_DIG = 2'h0;
  localparam logic [1:0] REF_EXT = 2'h1;
  localparam logic [1:0] REF_MST = 2'h2;
  // Test patterns
  localparam logic [1:0] TP_RAMP = 2'h0;
  localparam logic [1:0] TP_B75 = 2'h1;
  localparam logic [1:0] TP_B100 = 2'h2;
  // Blanking end line
  localparam logic [4:0] VB_NARROW = 5'h0_00A;
  localparam logic [4:0] VB_WIDE = 5'h0_014;
  localparam logic [4:0] VB_MIN = 5'h0_006;
  localparam logic [4:0] VB_MAX = 5'h0_019;
  // Cable length in metres
  localparam logic [8:0] CBL_MAX = 9'h0_15E;
  localparam logic [8:0] CBL_LOCAL = 9'h0_12C;
  localparam logic [8:0] CBL_DEF = 9'h0_000;
  // Timing limits, signed
  localparam logic signed [11:0] HT_LIM = 12'sh06B4;
  localparam logic signed [10:0] VT_LIM = 11'sh020D;
  localparam logic signed [7:0] FP_LIM = 8'sh46;
  // Gain percent, pedestal IRE
  localparam logic [6:0] GAIN_MAX = 7'h0_78;
  localparam logic [6:0] GAIN_DEF = 7'h0_64;
  localparam logic signed [4:0] PED_LIM = 5'sh0A;
  // Parameter select codes
  localparam logic [3:0] P_FMT = 4'h0;
  localparam logic [3:0] P_SETUP = 4'h1;
  localparam logic [3:0] P_REF = 4'h2;
  localparam logic [3:0] P_CLOCK = 4'h3;
  localparam logic [3:0] P_CABLE = 4'h4;
  localparam logic [3:0] P_TEN = 4'h5;
  localparam logic [3:0] P_TTYPE = 4'h6;
  localparam logic [3:0] P_VBLK = 4'h7;
  localparam logic [3:0] P_EDH = 4'h8;
  localparam logic [3:0] P_FINE = 4'h9;
  localparam logic [3:0] P_HT = 4'hA;
  localparam logic [3:0] P_VT = 4'hB;
  localparam logic [3:0] P_GAIN = 4'hC;
  localparam logic [3:0] P_PED = 4'hD;
  // Access level of each parameter
  localparam logic [1:0] LVL_1 = 2'h1;
  localparam logic [1:0] LVL_2 = 2'h2;
  localparam logic [1:0] LVL_3 = 2'h3;
  // Setup memory
  localparam int SLOTS = 5;
  localparam int SETUP_W = 68;
  localparam logic [2:0] SLOT_LAST = 3'h5;
endpackage

// >>> kdb_slot_mem.sv
// Five-slot setup store with occupancy flags
// Assumes a single clock domain and one save or recall per cycle
`timescale 1ns/1ps
module kdb_slot_mem
  import kdb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic save,
  input wire logic [2:0] save_slot,
  input wire logic [SETUP_W-1:0] save_data,
  input wire logic [2:0] rd_slot,
  output logic [SETUP_W-1:0] rd_data,
  output logic rd_full
);
  logic [SETUP_W-1:0] mem [SLOTS];
  logic [SLOTS-1:0] full;
  logic [SLOTS-1:0] next_full;

  always_comb begin
    next_full = full;
    if (save && save_slot >= 3'h1 && save_slot <= SLOT_LAST) begin
      next_full[save_slot - 3'h1] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      full <= '0;
    end else if (ce) begin
      full <= next_full;
    end
  end

  // Storage without reset, as a memory
  genvar g;
  for (g = 0; g < SLOTS; g++) begin : g_slot
    always_ff @(posedge clk) begin
      if (ce && save && save_slot == 3'(g + 1)) begin
        mem[g] <= save_data;
      end
    end
  end

  always_comb begin
    rd_data = '0;
    rd_full = 1'b0;
    if (rd_slot >= 3'h1 && rd_slot <= SLOT_LAST) begin
      rd_data = mem[rd_slot - 3'h1];
      rd_full = full[rd_slot - 3'h1];
    end
  end
endmodule

// >>> kdb_ctl_model.sv
// Remote controller model: parameter writes and setup memory commands
// Assumes one clock; requests change at the falling edge and are taken at the next rising edge
`timescale 1ns/1ps
module kdb_ctl_model
  import kdb_pkg::*;
(
  // Clock
  input wire logic clk,
  // Requests towards the bank
  output logic wr,
  output logic [3:0] wr_sel,
  output logic signed [15:0] wr_val,
  output logic save,
  output logic recall,
  output logic [2:0] slot
);
  initial begin
    wr = 1'b0;
    wr_sel = 4'h0;
    wr_val = 16'h0000;
    save = 1'b0;
    recall = 1'b0;
    slot = 3'h0;
  end

  // One-cycle write strobe; released data shows the inverse
  task automatic put(input logic [3:0] sel, input logic signed [15:0] val);
    @(negedge clk);
    wr = 1'b1;
    wr_sel = sel;
    wr_val = val;
    @(negedge clk);
    wr = 1'b0;
    wr_val = ~val;
  endtask

  task automatic mem(input logic sv, input logic rc, input logic [2:0] s);
    @(negedge clk);
    save = sv;
    recall = rc;
    slot = s;
    @(negedge clk);
    save = 1'b0;
    recall = 1'b0;
    slot = ~s;
  endtask

  task automatic genlock(input logic signed [15:0] vt, ht, fp);
    put(P_VT, vt);
    put(P_HT, ht);
    put(P_FINE, fp);
  endtask

  task automatic nudge(input logic signed [15:0] ht, d, fp);
    if (d > 16'sh0002) d = 16'sh0002;
    if (d < -16'sh0002) d = -16'sh0002;
    put(P_HT, ht + d);
    put(P_FINE, fp);
  endtask
endmodule

// >>> testbench.sv
// Self-checking bench for the key converter setting bank
// Assumes the controller model owns the request lines; the bench drives the rest at the falling edge
`timescale 1ns/1ps
module testbench;
  import kdb_pkg::*;
  logic REF_CLK = 1'b0;
  logic RST = 1'b1;
  logic CE = 1'b1;
  logic REMOTE = 1'b1;
  logic SW_BURST = 1'b1, SW_SETUP = 1'b1, SW_NARROW = 1'b0, SW_EDH = 1'b1;
  logic [1:0] USER_LEVEL = 2'h3;
  logic RX_EQ = 1'b0, RX_LOCK = 1'b0, RX_EDH = 1'b0, RX_EDH_ERR = 1'b0, RX_AUDIO = 1'b0;
  logic REF_OK = 1'b0, GL_FITTED = 1'b0;
  logic [8:0] RX_CABLE = 9'h000;
  logic [10:0] GL_DELAY = 11'h000;
  wire logic WR, SAVE, RECALL;
  wire logic [3:0] WR_SEL;
  wire logic signed [15:0] WR_VAL;
  wire logic [2:0] SLOT;
  logic FORMAT, SETUP_ON, TEST_EN, EDH_INS, WR_REFUSED, SLOT_EMPTY, LOCK_OK, EQ_OK;
  logic EDH_PRESENT, EDH_ERROR, AUDIO_PRESENT, REF_STATUS, GL_PRESENT;
  logic [1:0] REF_SRC, FIELD_PHASE, TEST_TYPE;
  logic [8:0] CABLE_MAX, CABLE_LEN;
  logic [4:0] VBLANK_END;
  logic signed [7:0] FINE_PHASE;
  logic signed [11:0] HOR_TIMING;
  logic signed [10:0] VERT_TIMING;
  logic [10:0] DELAY_LINES;
  logic [6:0] GAIN;
  logic signed [4:0] PEDESTAL;
  logic [13:0] PARAM_AVAIL;
  int n_fail = 0;
  int checks = 0;
  logic [15:0] dflt [14] = '{16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001,
    16'h0014, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0000};
  logic [3:0] c_sel [21] = '{P_GAIN, P_GAIN, P_PED, P_PED, P_HT, P_HT, P_VT, P_VT, P_FINE, P_CABLE,
    P_VBLK, P_VBLK, P_VBLK, P_TTYPE, P_TTYPE, P_REF, P_REF, P_EDH, P_EDH, P_SETUP, P_SETUP};
  logic [15:0] c_val [21] = '{16'h00C8, 16'hFFFB, 16'h000F, 16'hFFF1, 16'h07D0, 16'hF94C, 16'h0258,
    16'hFDA8, 16'hFF9C, 16'h0190, 16'h0003, 16'h001E, 16'h000A, 16'h0003, 16'h0000, 16'h0003, 16'h0001,
    16'h0000, 16'h0001, 16'h0000, 16'h0001};
  logic [15:0] c_exp [21] = '{16'h0078, 16'h0000, 16'h000A, 16'hFFF6, 16'h06B4, 16'hF94C, 16'h020D,
    16'hFDF3, 16'hFFBA, 16'h015E, 16'h0006, 16'h0019, 16'h000A, 16'h0002, 16'h0000, 16'h0002, 16'h0001,
    16'h0000, 16'h0001, 16'h0000, 16'h0001};
  logic [1:0] cl_exp [5] = '{PH_ARB, PH_MATCH, PH_OPP, PH_OPP, PH_OPP};
  logic [13:0] av_exp [3] = '{14'h3000, 14'h3060, 14'h3FFF};

  always #4 REF_CLK = ~REF_CLK;

  kdb_bank i_dut (.REF_CLK, .RST, .CE, .REMOTE, .SW_BURST, .SW_SETUP, .SW_NARROW, .SW_EDH, .WR, .WR_SEL,
    .WR_VAL, .USER_LEVEL, .SAVE, .RECALL, .SLOT, .RX_EQ, .RX_LOCK, .RX_CABLE, .RX_EDH, .RX_EDH_ERR, .RX_AUDIO,
    .REF_OK, .GL_FITTED, .GL_DELAY, .FORMAT, .SETUP_ON, .REF_SRC, .FIELD_PHASE, .CABLE_MAX, .TEST_EN,
    .TEST_TYPE, .VBLANK_END, .EDH_INS, .FINE_PHASE, .HOR_TIMING, .VERT_TIMING, .GAIN, .PEDESTAL,
    .PARAM_AVAIL, .WR_REFUSED, .SLOT_EMPTY, .LOCK_OK, .EQ_OK, .CABLE_LEN, .EDH_PRESENT, .EDH_ERROR,
    .AUDIO_PRESENT, .REF_STATUS, .GL_PRESENT, .DELAY_LINES);

  kdb_ctl_model i_ctl (.clk(REF_CLK), .wr(WR), .wr_sel(WR_SEL), .wr_val(WR_VAL), .save(SAVE),
    .recall(RECALL), .slot(SLOT));

  task automatic summarize();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge REF_CLK);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Active setting seen at the port for each parameter code
  function automatic logic [15:0] out(input logic [3:0] sel);
    case (sel)
      P_FMT: return 16'(FORMAT);
      P_SETUP: return 16'(SETUP_ON);
      P_REF: return 16'(REF_SRC);
      P_CLOCK: return 16'(FIELD_PHASE);
      P_CABLE: return 16'(CABLE_MAX);
      P_TEN: return 16'(TEST_EN);
      P_TTYPE: return 16'(TEST_TYPE);
      P_VBLK: return 16'(VBLANK_END);
      P_EDH: return 16'(EDH_INS);
      P_FINE: return 16'(FINE_PHASE);
      P_HT: return 16'(HOR_TIMING);
      P_VT: return 16'(VERT_TIMING);
      P_GAIN: return 16'(GAIN);
      default: return 16'(PEDESTAL);
    endcase
  endfunction

  task automatic chk_dflt();
    for (int i = 0; i < 14; i++) chk(out(4'(i)), dflt[i], "default");
  endtask

  initial begin
    #100000;
    n_fail++;
    summarize();
  end

  initial begin
    tick(3);
    RST = 1'b0;
    tick(1);
    chk_dflt();
    // Status follows the datapath inputs
    for (int i = 0; i < 4; i++) begin
      RX_EQ = i[0];
      RX_LOCK = i[1];
      tick(2);
      chk(16'(LOCK_OK), 16'(i[0] & i[1]), "lock flag");
      chk(16'(EQ_OK), 16'(i[0]), "eq flag");
    end
    RX_CABLE = 9'h0C8;
    RX_EDH = 1'b1;
    RX_EDH_ERR = 1'b1;
    RX_AUDIO = 1'b1;
    REF_OK = 1'b1;
    GL_DELAY = 11'h1F3;
    tick(2);
    chk(16'(CABLE_LEN), 16'h00C8, "cable length");
    chk(16'({EDH_PRESENT, EDH_ERROR, AUDIO_PRESENT}), 16'h0007, "edh audio");
    chk(16'({REF_STATUS, GL_PRESENT}), 16'h0002, "ref option");
    chk(16'(DELAY_LINES), 16'h0000, "delay absent");
    GL_FITTED = 1'b1;
    RX_EDH = 1'b0;
    tick(2);
    chk(16'({EDH_PRESENT, EDH_ERROR, GL_PRESENT}), 16'h0001, "edh gone");
    chk(16'(DELAY_LINES), 16'h01F3, "delay lines");
    // Ranges and clamping
    for (int i = 0; i < 21; i++) begin
      i_ctl.put(c_sel[i], c_val[i]);
      tick(2);
      chk(out(c_sel[i]), c_exp[i], "clamp");
    end
    // Colour lock codes, composite active
    for (int i = 0; i < 6; i++) begin
      i_ctl.put(P_CLOCK, 16'(i));
      tick(2);
      chk(16'(FIELD_PHASE), 16'(cl_exp[i > 4 ? 4 : i]), "colour lock");
    end
    i_ctl.put(P_FMT, 16'h0000);
    i_ctl.put(P_CLOCK, 16'h0001);
    tick(2);
    chk(16'(FIELD_PHASE), 16'(PH_ARB), "lock off composite");
    i_ctl.put(P_FMT, 16'h0001);
    tick(2);
    chk(16'(FIELD_PHASE), 16'(PH_MATCH), "lock after format");
    // Access levels
    for (int i = 0; i < 3; i++) begin
      USER_LEVEL = 2'(i + 1);
      tick(2);
      chk(16'(PARAM_AVAIL), 16'(av_exp[i]), "avail");
    end
    USER_LEVEL = LVL_1;
    i_ctl.put(P_SETUP, 16'h0000);
    chk(16'(WR_REFUSED), 16'h0001, "refused");
    tick(1);
    tick(1);
    chk(16'(SETUP_ON), 16'h0001, "setup kept");
    USER_LEVEL = LVL_2;
    i_ctl.put(P_TEN, 16'h0001);
    chk(16'(WR_REFUSED), 16'h0000, "accepted");
    tick(1);
    tick(1);
    chk(16'(TEST_EN), 16'h0001, "test on");
    USER_LEVEL = LVL_3;
    // Genlock timing
    i_ctl.genlock(16'h0010, 16'h0064, 16'h0014);
    tick(2);
    chk(16'(VERT_TIMING), 16'h0010, "vert");
    chk(16'(HOR_TIMING), 16'h0064, "hor");
    i_ctl.nudge(16'h0064, 16'h0005, 16'h001E);
    tick(2);
    chk(16'(HOR_TIMING), 16'h0066, "nudge");
    chk(16'(FINE_PHASE), 16'h001E, "fine");
    // Local mode, then remote again
    i_ctl.put(P_VBLK, 16'h000C);
    i_ctl.put(P_GAIN, 16'h0032);
    REMOTE = 1'b0;
    SW_SETUP = 1'b0;
    SW_NARROW = 1'b1;
    SW_EDH = 1'b0;
    tick(2);
    chk(16'({SETUP_ON, EDH_INS, FORMAT}), 16'h0001, "switches");
    chk(16'(VBLANK_END), 16'(VB_NARROW), "narrow");
    chk(16'(CABLE_MAX), 16'(CBL_LOCAL), "local cable");
    chk(16'({REF_SRC, FIELD_PHASE}), 16'({REF_EXT, PH_MATCH}), "local ref");
    chk(16'({TEST_EN, GAIN}), 16'(GAIN_DEF), "local defaults");
    i_ctl.put(P_GAIN, 16'h0046);
    chk(16'(WR_REFUSED), 16'h0001, "local write");
    tick(1);
    REMOTE = 1'b1;
    tick(2);
    chk(16'(VBLANK_END), 16'h000C, "remote wins");
    chk(16'(GAIN), 16'h0032, "remote gain");
    // Setup memory
    i_ctl.mem(1'b1, 1'b0, 3'h2);
    i_ctl.put(P_GAIN, 16'h0050);
    i_ctl.put(P_VBLK, 16'h0008);
    i_ctl.mem(1'b0, 1'b1, 3'h2);
    chk(16'(SLOT_EMPTY), 16'h0000, "slot full");
    tick(1);
    tick(1);
    chk(16'({GAIN, VBLANK_END}), 16'({7'h32, 5'h0C}), "recall");
    i_ctl.mem(1'b0, 1'b1, 3'h4);
    chk(16'(SLOT_EMPTY), 16'h0001, "slot empty");
    tick(1);
    tick(1);
    chk(16'(GAIN), 16'h0032, "empty no load");
    // Frozen while CE low
    CE = 1'b0;
    i_ctl.put(P_GAIN, 16'h0014);
    tick(2);
    CE = 1'b1;
    tick(2);
    chk(16'(GAIN), 16'h0032, "frozen");
    // Second reset clears settings and occupancy
    RST = 1'b1;
    tick(1);
    RST = 1'b0;
    tick(1);
    chk_dflt();
    i_ctl.mem(1'b0, 1'b1, 3'h2);
    chk(16'(SLOT_EMPTY), 16'h0001, "cleared");
    tick(1);
    tick(2);
    summarize();
  end
endmodule
